// File: hdl/deflection_sync_control_status.sv
// Two-wire slave with write-only control registers, status byte and sync processor logic.
// Assumes open-drain data resolved outside, a free-running sync_clk, and a supply monitor level.
`timescale 1ns/1ns
module deflection_sync_control_status (
   input wire logic core_clk, // Core clock, 100 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic sync_clk, // Sync sampling clock.
   input wire logic supply_ok, // Supply in normal operation.
   input wire logic scl_in, // Serial clock line level.
   input wire logic sda_in, // Serial data line level.
   output logic sda_out, // Serial data drive value, always low.
   output logic sda_oe, // High while pulling data low.
   input wire logic composite_sync_input, // Composite or horizontal sync.
   input wire logic vertical_sync_input, // Pure vertical sync.
   input wire logic loop_locked_in, // Horizontal loop coincidence detector.
   input wire logic vertical_amplitude_unlocked, // Vertical amplitude loop not settled.
   input wire logic overvoltage_event, // Overvoltage comparator.
   input wire logic vertical_blank, // Vertical blanking from vertical section.
   output deflection_pkg::drive_s drive_enables, // Drive output enables.
   output logic lock_blank_output_pin, // Composite lock and blanking.
   output deflection_pkg::pump_current_e pump_current, // Charge pump current level.
   output logic pump_output_hiz, // Charge pump output floated.
   output logic loop_sync_leading_edge, // Leading edge pulse to the loop.
   output logic horizontal_sync_positive, // Positive-going sync to horizontal section.
   output logic deflection_vertical_sync // Selected vertical sync.
);
   import deflection_pkg::*;

   // ----------------------------------------
   // State of both domains
   // ----------------------------------------
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] clean;
      logic [1:0] line_f;
      logic [1:0] line_p;
      logic [1:0][2:0] filt_cnt;
      i2c_state_e st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] sub;
      logic is_read;
      logic master_nak;
      logic sda_oe;
      logic [NUM_SUBADDR-1:0][7:0] regs;
      logic [2:0] t1;
      logic [2:0] t2;
      logic [2:0] t3;
      logic [1:0] p1;
      logic [1:0] p2;
      logic [2:0] seen;
      logic alarm;
      logic src_sel;
      drive_s drive;
      pump_current_e pump;
      logic lock_blank;
   } core_s;

   typedef struct packed {
      logic [1:0] r;
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] clean;
      logic [1:0] raw_p;
      logic [1:0] prev;
      logic [1:0] neg;
      logic [1:0][POL_CNT_W-1:0] hi_cnt;
      logic [1:0][POL_CNT_W-1:0] lo_cnt;
      logic [7:0] extr_cnt;
      logic extr;
      logic [2:0] tog;
      logic [1:0] c1;
      logic [1:0] c2;
      logic hsync_pos;
      logic vsync_out;
      logic pump_hiz;
      logic lead_edge;
   } sync_s;

   core_s q, d;
   sync_s sq, sd;
   status_s status_now;
   logic scl_rise, scl_fall, start_cond, stop_cond, wr, clr_flags, clr_alarm;
   logic [2:0] seen_set;
   logic [1:0] corrected;

   // ----------------------------------------
   // Core domain: pins, bus slave, flags
   // ----------------------------------------
   // Next state of the core domain.
   always_comb begin
      d = q;
      wr = 1'b0;
      // Status byte built from live flags.
      status_now.horizontal_loop_unlocked = !q.clean[IN_LOCKED];
      status_now.vertical_amplitude_unlocked = q.clean[IN_AMP_UNLOCKED];
      status_now.overvoltage_alarm_flag = q.alarm;
      status_now.composite_input_negative = q.p2[1];
      status_now.vertical_input_negative = q.p2[0];
      status_now.extracted_vertical_seen = q.seen[2];
      status_now.composite_input_seen = q.seen[1];
      status_now.vertical_input_seen = q.seen[0];
      // Three-stage synchronisers; a change counts once the second and third stages agree.
      d.s1 = {supply_ok, overvoltage_event, vertical_amplitude_unlocked, loop_locked_in, sda_in, scl_in};
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.clean = (q.s2 & q.s3) | (q.clean & (q.s2 ^ q.s3));
      // Bus lines must differ for FILT_CYCLES cycles before the filtered level follows.
      for (int i = 0; i < 2; i++) begin
         if (q.clean[i] == q.line_f[i]) begin
            d.filt_cnt[i] = 3'h0;
         end else if (q.filt_cnt[i] == FILT_LIMIT) begin
            d.filt_cnt[i] = 3'h0;
            d.line_f[i] = q.clean[i];
         end else begin
            d.filt_cnt[i] = q.filt_cnt[i] + 3'h1;
         end
      end
      d.line_p = q.line_f;
      scl_rise = q.line_f[0] & !q.line_p[0];
      scl_fall = !q.line_f[0] & q.line_p[0];
      start_cond = q.line_f[0] & q.line_p[0] & q.line_p[1] & !q.line_f[1];
      stop_cond = q.line_f[0] & q.line_p[0] & !q.line_p[1] & q.line_f[1];
      // Protocol engine; a start anywhere restarts addressing.
      if (!q.clean[IN_SUPPLY]) begin
         d.st = ST_IDLE;
         d.sda_oe = 1'b0;
      end else if (start_cond) begin
         d.st = ST_ADDR;
         d.bitcnt = 4'h0;
         d.sda_oe = 1'b0;
      end else if (stop_cond) begin
         d.st = ST_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            ST_IDLE: begin
            end
            ST_ADDR, ST_SUB, ST_WDATA: begin
               if (scl_rise) begin
                  d.shreg = {q.shreg[6:0], q.line_f[1]};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == 4'h8) begin
                  d.bitcnt = 4'h0;
                  d.sda_oe = 1'b1;
                  if (q.st == ST_ADDR) begin
                     d.st = ST_ADDR_ACK;
                     d.is_read = (q.shreg == ADDR_READ);
                     if (q.shreg != ADDR_READ && q.shreg != ADDR_WRITE) begin
                        d.st = ST_IDLE;
                        d.sda_oe = 1'b0;
                     end
                  end else if (q.st == ST_SUB) begin
                     d.sub = q.shreg;
                     d.st = ST_SUB_ACK;
                  end else begin
                     wr = 1'b1;
                     d.st = ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.st = ST_SUB;
                  if (q.is_read) begin
                     d.st = ST_RDATA;
                     d.shreg = status_now;
                     d.sda_oe = !status_now[7];
                  end
               end
            end
            ST_SUB_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.st = ST_WDATA;
               end
            end
            ST_WDATA_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.st = ST_WDATA;
                  d.sub = q.sub + 8'h01;
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == 4'h8) begin
                  d.st = ST_RACK;
                  d.bitcnt = 4'h0;
                  d.sda_oe = 1'b0;
               end else if (scl_fall) begin
                  d.shreg = {q.shreg[6:0], 1'b0};
                  d.sda_oe = !q.shreg[6];
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  d.master_nak = q.line_f[1];
               end else if (scl_fall) begin
                  d.st = ST_IDLE;
                  if (!q.master_nak) begin
                     d.st = ST_RDATA;
                     d.shreg = status_now;
                     d.sda_oe = !status_now[7];
                  end
               end
            end
            default: begin
               d.st = ST_IDLE;
               d.sda_oe = 1'b0;
            end
         endcase
      end
      // Register write at the start of the data acknowledge; commands act here and self-clear.
      clr_flags = wr && q.sub == SUB_CTRL_A && q.shreg[CA_FLAGS_CLEAR];
      clr_alarm = wr && q.sub == SUB_CTRL_A && q.shreg[CA_ALARM_CLEAR];
      if (wr && q.sub < SUB_LIMIT) begin
         d.regs[q.sub[4:0]] = q.shreg;
         if (q.sub == SUB_CTRL_A) begin
            d.regs[q.sub[4:0]][CA_FLAGS_CLEAR] = 1'b0;
            d.regs[q.sub[4:0]][CA_ALARM_CLEAR] = 1'b0;
         end
      end
      if (!q.clean[IN_SUPPLY]) begin
         d.regs = '0;
      end
      // Pulse events arrive as toggles; a set in the clearing cycle wins.
      d.t1 = sq.tog;
      d.t2 = q.t1;
      d.t3 = q.t2;
      d.p1 = sq.neg;
      d.p2 = q.p1;
      seen_set = q.t2 ^ q.t3;
      d.seen = (q.seen & ~{3{clr_flags}}) | seen_set;
      d.alarm = (q.alarm & !clr_alarm) | q.clean[IN_ALARM];
      // Vertical source choice, manual or automatic.
      if (q.regs[SUB_CTRL_A][CA_AUTO]) begin
         if (q.seen[0] && q.seen[2]) begin
            d.src_sel = q.src_sel;
         end else if (q.seen[0]) begin
            d.src_sel = 1'b1;
         end else if (q.seen[2]) begin
            d.src_sel = 1'b0;
         end
      end else begin
         d.src_sel = q.regs[SUB_CTRL_A][CA_SOURCE_SEL];
      end
      // Outputs toward drive, pump and lock pin.
      d.drive.horizontal_drive_output = q.clean[IN_SUPPLY] && q.regs[SUB_CTRL_B][CB_HBOUT_EN] && !q.alarm;
      d.drive.boost_drive_output = q.clean[IN_SUPPLY] && q.regs[SUB_CTRL_B][CB_HBOUT_EN] && !q.alarm;
      d.drive.vertical_ramp_output = q.clean[IN_SUPPLY] && q.regs[SUB_CTRL_B][CB_VRAMP_EN];
      if (!q.clean[IN_LOCKED]) begin
         d.pump = PUMP_VERY_LOW;
      end else begin
         d.pump = q.regs[SUB_CTRL_A][CA_PUMP_HIGH] ? PUMP_HIGH : PUMP_LOW;
      end
      d.lock_blank = (q.regs[SUB_CTRL_A][CA_LOCK_EN] && !q.clean[IN_LOCKED]) || vertical_blank;
      if (!rst_n) begin
         d = '0;
         d.s1 = IN_RESET;
         d.s2 = IN_RESET;
         d.s3 = IN_RESET;
         d.clean = IN_RESET;
         d.line_f = 2'h3;
         d.line_p = 2'h3;
         d.st = ST_IDLE;
         d.pump = PUMP_VERY_LOW;
      end
   end

   // Core domain register.
   always_ff @(posedge core_clk) begin
      q <= d;
   end

   // ----------------------------------------
   // Sync domain: polarity, presence, extraction
   // ----------------------------------------
   // Next state of the sync domain; index 0 is vertical, 1 is composite.
   always_comb begin
      sd = sq;
      sd.r = {sq.r[0], rst_n};
      sd.s1 = {composite_sync_input, vertical_sync_input};
      sd.s2 = sq.s1;
      sd.s3 = sq.s2;
      sd.clean = (sq.s2 & sq.s3) | (sq.clean & (sq.s2 ^ sq.s3));
      sd.raw_p = sq.clean;
      corrected = sq.clean ^ sq.neg;
      sd.prev = corrected;
      for (int i = 0; i < 2; i++) begin
         // High time longer than low time means pulses go low.
         if (sq.clean[i] && !sq.raw_p[i]) begin
            sd.neg[i] = sq.hi_cnt[i] > sq.lo_cnt[i];
            sd.hi_cnt[i] = '0;
            sd.lo_cnt[i] = '0;
         end else if (sq.clean[i] && !(&sq.hi_cnt[i])) begin
            sd.hi_cnt[i] = sq.hi_cnt[i] + 1'b1;
         end else if (!sq.clean[i] && !(&sq.lo_cnt[i])) begin
            sd.lo_cnt[i] = sq.lo_cnt[i] + 1'b1;
         end
         sd.tog[i] = sq.tog[i] ^ (corrected[i] & !sq.prev[i]);
      end
      // Integrating extractor: a long high stretch of composite sync is vertical sync.
      if (!corrected[1]) begin
         sd.extr_cnt = 8'h00;
      end else if (sq.extr_cnt != EXTR_LIMIT) begin
         sd.extr_cnt = sq.extr_cnt + 8'h01;
      end
      sd.extr = corrected[1] && sq.extr_cnt == EXTR_LIMIT;
      sd.tog[2] = sq.tog[2] ^ (sd.extr & !sq.extr);
      // Control levels from the core domain cross through two flip-flops.
      sd.c1 = {q.regs[SUB_CTRL_A][CA_INHIBIT_EN], q.src_sel};
      sd.c2 = sq.c1;
      sd.hsync_pos = corrected[1];
      sd.lead_edge = corrected[1] && !sq.prev[1];
      sd.vsync_out = sq.c2[0] ? corrected[0] : sq.extr;
      sd.pump_hiz = sq.c2[1] && sq.extr;
      if (!sq.r[1]) begin
         sd = '0;
         sd.r = {sq.r[0], rst_n};
      end
   end

   // Sync domain register.
   always_ff @(posedge sync_clk) begin
      sq <= sd;
   end

   // Port drive from registered state; sda_out is a constant low.
   assign sda_out = 1'b0;
   assign sda_oe = q.sda_oe;
   assign drive_enables = q.drive;
   assign lock_blank_output_pin = q.lock_blank;
   assign pump_current = q.pump;
   assign pump_output_hiz = sq.pump_hiz;
   assign loop_sync_leading_edge = sq.lead_edge;
   assign horizontal_sync_positive = sq.hsync_pos;
   assign deflection_vertical_sync = sq.vsync_out;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence ack_to_read;
      (q.st == ST_ADDR_ACK) ##1 (q.st == ST_RDATA);
   endsequence

   supply_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !q.clean[IN_SUPPLY] |=> !q.sda_oe && q.drive == 3'h0 && q.st == ST_IDLE)
      else $error("Bus or drives active without supply.");
   regs_default_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !q.clean[IN_SUPPLY] |=> q.regs == '0)
      else $error("Registers not at default without supply.");
   addr_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.st == ST_ADDR_ACK && $past(q.st) == ST_ADDR) |-> (q.shreg == ADDR_WRITE || q.shreg == ADDR_READ))
      else $error("Acknowledged a foreign address.");
   spike_filter_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $changed(q.line_f[0]) |-> $past(q.filt_cnt[0]) == FILT_LIMIT)
      else $error("Clock line followed a short spike.");
   sub_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.st == ST_WDATA_ACK && scl_fall && !start_cond && !stop_cond && q.clean[IN_SUPPLY])
      |=> q.st == ST_WDATA && q.sub == $past(q.sub) + 8'h01)
      else $error("Subaddress did not step after a data byte.");
   read_status_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      ack_to_read |-> q.shreg == $past(status_now) && q.sda_oe == !$past(status_now[7]))
      else $error("Read did not start with the status byte.");
   sticky_flags_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.seen != 3'h0 && !clr_flags) |=> (q.seen & $past(q.seen)) == $past(q.seen))
      else $error("Presence flag dropped without a clear.");
   clear_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clr_flags && seen_set == 3'h0) |=> q.seen == 3'h0 ##1 q.regs[SUB_CTRL_A][CA_FLAGS_CLEAR] == 1'b0)
      else $error("Flags not cleared at the acknowledge.");
   auto_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.regs[SUB_CTRL_A][CA_AUTO] && q.seen[0] && q.seen[2]) |=> $stable(q.src_sel))
      else $error("Automatic mode switched with both sources present.");
   pump_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !q.clean[IN_LOCKED] |=> q.pump == PUMP_VERY_LOW)
      else $error("Pump current not lowest while unlocked.");
   lock_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (q.regs[SUB_CTRL_A][CA_LOCK_EN] && !q.clean[IN_LOCKED]) |=> q.lock_blank)
      else $error("Unlock not shown on the lock pin.");
   leading_edge_a: assert property (@(posedge sync_clk) disable iff (!sq.r[1])
      sq.lead_edge |-> sq.prev[1] && !$past(sq.prev[1]))
      else $error("Loop edge pulse not on a leading edge.");
   pump_hiz_a: assert property (@(posedge sync_clk) disable iff (!sq.r[1])
      !sq.c2[1] |=> !sq.pump_hiz)
      else $error("Pump floated while inhibition disabled.");
endmodule

// File: hdl/deflection_pkg.sv
// Constants, enumerations and carrier types of the deflection sync control block.
// Assumes a 100 MHz core clock and a free-running sync sampling clock of 64 ns period.
package deflection_pkg;
   // ----------------------------------------
   // Bus addresses and register layout
   // ----------------------------------------
   localparam logic [7:0] ADDR_WRITE = 8'h8c;
   localparam logic [7:0] ADDR_READ = 8'h8d;
   localparam int NUM_SUBADDR = 18;
   localparam logic [7:0] SUB_LIMIT = 8'(NUM_SUBADDR);
   localparam logic [7:0] SUB_CTRL_A = 8'h10;
   localparam logic [7:0] SUB_CTRL_B = 8'h11;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int CA_LOCK_EN = 0;
   localparam int CA_INHIBIT_EN = 1;
   localparam int CA_PUMP_HIGH = 2;
   localparam int CA_FLAGS_CLEAR = 4;
   localparam int CA_SOURCE_SEL = 5;
   localparam int CA_AUTO = 6;
   localparam int CA_ALARM_CLEAR = 7;
   localparam int CB_VRAMP_EN = 1;
   localparam int CB_HBOUT_EN = 2;
   // Index of each asynchronous core-side input in the synchroniser vector.
   localparam int IN_SCL = 0;
   localparam int IN_SDA = 1;
   localparam int IN_LOCKED = 2;
   localparam int IN_AMP_UNLOCKED = 3;
   localparam int IN_ALARM = 4;
   localparam int IN_SUPPLY = 5;
   localparam logic [5:0] IN_RESET = 6'h03;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CORE_PERIOD_NS = 10;
   localparam int SPIKE_NS = 50;
   localparam int FILT_CYCLES = (SPIKE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS + 1;
   localparam logic [2:0] FILT_LIMIT = 3'(FILT_CYCLES - 1);
   localparam int SYNC_PERIOD_NS = 64;
   localparam int EXTR_NS = 8000;
   localparam int EXTR_CYCLES = (EXTR_NS + SYNC_PERIOD_NS - 1) / SYNC_PERIOD_NS;
   localparam logic [7:0] EXTR_LIMIT = 8'(EXTR_CYCLES);
   localparam int POL_CNT_W = 20;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_ADDR_ACK = 4'h3, ST_SUB = 4'h2, ST_SUB_ACK = 4'h6,
      ST_WDATA = 4'h7, ST_WDATA_ACK = 4'h5, ST_RDATA = 4'h4, ST_RACK = 4'hc
   } i2c_state_e;
   typedef enum logic [1:0] {PUMP_VERY_LOW = 2'h0, PUMP_LOW = 2'h1, PUMP_HIGH = 2'h3} pump_current_e;
   typedef struct packed {
      logic horizontal_loop_unlocked;
      logic vertical_amplitude_unlocked;
      logic overvoltage_alarm_flag;
      logic composite_input_negative;
      logic vertical_input_negative;
      logic extracted_vertical_seen;
      logic composite_input_seen;
      logic vertical_input_seen;
   } status_s;
   typedef struct packed {
      logic horizontal_drive_output;
      logic boost_drive_output;
      logic vertical_ramp_output;
   } drive_s;
endpackage

// File: testbench/bus_host.sv
// Two-wire bus master model for the deflection control block.
// Assumes the data line is resolved outside with a pull-up.
`timescale 1ns/1ns
module bus_host #(
   parameter int Q = 63 // Core cycles per quarter bit.
) (
   input wire logic core_clk, // Core clock.
   input wire logic sda_line, // Resolved data line.
   output logic scl = 1'b1, // Clock line.
   output logic sda_low = 1'b0 // High pulls data low.
);
   // Waits a quarter bit.
   task automatic w();
      repeat (Q) @(posedge core_clk);
   endtask
   // Start, also usable as a repeated start.
   task automatic start();
      sda_low <= 1'b0;
      w();
      scl <= 1'b1;
      w();
      sda_low <= 1'b1;
      w();
      scl <= 1'b0;
      w();
   endtask
   // Stop, entered with the clock low.
   task automatic stop();
      sda_low <= 1'b1;
      w();
      scl <= 1'b1;
      w();
      sda_low <= 1'b0;
      w();
   endtask
   // One bit out and in; the line is sampled mid-high.
   task automatic bit_io(input logic b, output logic r);
      sda_low <= !b;
      w();
      scl <= 1'b1;
      w();
      r = sda_line;
      w();
      scl <= 1'b0;
      w();
   endtask
   // Byte out MSB first; a ninth bit of 1 releases for ack or gives no-acknowledge.
   task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
         r = {r[6:0], b};
      end
      bit_io(1'b1, b);
      ack = !b;
   endtask
endmodule

// File: testbench/deflection_sync_control_status_tb.sv
// Self-checking bench: status reads, register writes, sync flags and supply loss.
// Assumes the design package and the bus host model are compiled first.
`timescale 1ns/1ns
module deflection_sync_control_status_tb;
   import deflection_pkg::*;
   logic core_clk = 0, sync_clk = 0, rst_n = 0, supply_ok = 1, comp = 0, vert = 0, locked = 0;
   logic scl, m_low, sda_oe;
   logic lockpin, hiz_o, lead, hpos, vsel, amp_unl = 0, alarm = 0;
   int n_edges = 0, e = 0;
   drive_s drv;
   pump_current_e pump;
   int n_fail = 0, n_compared = 0;
   wire sda = !(m_low | sda_oe);
   initial forever #5 core_clk = !core_clk;
   initial begin
      #3;
      forever #32 sync_clk = !sync_clk;
   end
   bus_host i_bus_host (.core_clk(core_clk), .sda_line(sda), .scl(scl), .sda_low(m_low));
   deflection_sync_control_status i_deflection_sync_control_status (.core_clk(core_clk), .rst_n(rst_n),
      .sync_clk(sync_clk), .supply_ok(supply_ok), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .composite_sync_input(comp), .vertical_sync_input(vert), .loop_locked_in(locked),
      .vertical_amplitude_unlocked(amp_unl), .overvoltage_event(alarm), .vertical_blank(1'b0),
      .drive_enables(drv), .lock_blank_output_pin(lockpin), .pump_current(pump), .pump_output_hiz(hiz_o),
      .loop_sync_leading_edge(lead), .horizontal_sync_positive(hpos), .deflection_vertical_sync(vsel));
   // Counts the leading edge pulses handed to the loop.
   always @(posedge sync_clk) begin
      if (lead === 1'b1) n_edges <= n_edges + 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Reads status, directly or after a subaddress and a repeated start.
   task automatic rd(input logic [7:0] exp, input logic direct);
      logic [7:0] r;
      logic a;
      if (!direct) begin
         i_bus_host.start();
         i_bus_host.xfer(ADDR_WRITE, r, a);
         i_bus_host.xfer(8'h05, r, a);
      end
      i_bus_host.start();
      i_bus_host.xfer(ADDR_READ, r, a);
      chk(8'(a), 8'h01);
      i_bus_host.xfer(8'hff, r, a);
      chk(r, exp);
      i_bus_host.stop();
   endtask
   // Two data bytes to consecutive subaddresses.
   task automatic wr(input logic [7:0] adr, input logic [15:0] d, input logic ak);
      logic [7:0] r;
      logic a;
      i_bus_host.start();
      i_bus_host.xfer(adr, r, a);
      chk(8'(a), 8'(ak));
      if (a === 1'b1) begin
         i_bus_host.xfer(SUB_CTRL_A, r, a);
         i_bus_host.xfer(d[15:8], r, a);
         i_bus_host.xfer(d[7:0], r, a);
      end
      i_bus_host.stop();
   endtask
   // One composite pulse long enough to count as vertical sync.
   task automatic long_pulse(input logic [7:0] v, input logic [7:0] hiz);
      @(posedge sync_clk) comp <= 1'b1;
      repeat (145) @(posedge sync_clk);
      chk(8'(hpos), 8'h01);
      chk(8'(vsel), v);
      chk(8'(hiz_o), hiz);
      comp <= 1'b0;
      repeat (20) @(posedge sync_clk);
   endtask
   // Holds the vertical input high and checks the selected vertical sync.
   task automatic vhold(input logic [7:0] v);
      @(posedge sync_clk) vert <= 1'b1;
      repeat (10) @(posedge sync_clk);
      chk(8'(vsel), v);
      vert <= 1'b0;
      repeat (10) @(posedge sync_clk);
   endtask
   // Four short positive pulses on the inputs chosen by the mask.
   task automatic pulses(input logic [1:0] on);
      repeat (4) begin
         @(posedge sync_clk) comp <= on[1];
         vert <= on[0];
         repeat (4) @(posedge sync_clk);
         comp <= 1'b0;
         vert <= 1'b0;
         repeat (40) @(posedge sync_clk);
      end
   endtask
   initial begin
      repeat (30) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (30) @(posedge core_clk);
      rd(8'h80, 1'b0);
      wr(8'h8e, 16'h0, 1'b0);
      e = n_edges;
      pulses(2'h3);
      chk(8'(n_edges - e), 8'h04);
      locked <= 1'b1;
      repeat (100) @(posedge core_clk);
      rd(8'h03, 1'b1);
      $display("flags latched test done");
      wr(ADDR_WRITE, 16'h3404, 1'b1);
      chk(8'(drv), 8'h06);
      chk(8'(pump), 8'(PUMP_HIGH));
      repeat (100) @(posedge core_clk);
      rd(8'h00, 1'b1);
      vhold(8'h01);
      pulses(2'h3);
      repeat (100) @(posedge core_clk);
      rd(8'h03, 1'b1);
      locked <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk(8'(pump), 8'(PUMP_VERY_LOW));
      $display("clear and write test done");
      wr(ADDR_WRITE, 16'h5304, 1'b1);
      long_pulse(8'h01, 8'h01);
      @(posedge core_clk) amp_unl <= 1'b1;
      alarm <= 1'b1;
      repeat (10) @(posedge core_clk);
      alarm <= 1'b0;
      repeat (10) @(posedge core_clk);
      rd(8'he6, 1'b1);
      chk(8'(lockpin), 8'h01);
      wr(ADDR_WRITE, 16'h5004, 1'b1);
      pulses(2'h1);
      vhold(8'h01);
      long_pulse(8'h00, 8'h00);
      $display("source select test done");
      supply_ok <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk(8'(drv), 8'h00);
      wr(ADDR_WRITE, 16'h0004, 1'b0);
      supply_ok <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk(8'(drv), 8'h00);
      $display("supply loss test done");
      results();
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      results();
   end
endmodule
